//--- logic/pi_ctrl_regs.vh
// constants for the pi process controller: register map, fields, resets, timing
// assumes 32-bit avalon-mm slave with word addressing by byte offset
`ifndef PI_CTRL_REGS_VH
`define PI_CTRL_REGS_VH
`define OFS_CTRL 8'h00
`define OFS_SETPOINT 8'h04
`define OFS_PGAIN 8'h08
`define OFS_IPERIOD 8'h0c
`define OFS_MANUAL 8'h10
`define OFS_SCALE_GAIN 8'h14
`define OFS_SCALE_OFFSET 8'h18
`define OFS_PV_MIN 8'h1c
`define OFS_PV_MAX 8'h20
`define OFS_STATUS 8'h24
`define OFS_PV_SCALED 8'h28
`define OFS_OUTPUT 8'h2c
`define CTRL_AUTO_BIT 0
`define CTRL_SENSE_BIT 1
`define CTRL_SP_SRC_BIT 2
`define CTRL_MQ_SRC_BIT 3
`define CTRL_DEC_LSB 4
`define CTRL_RESET 32'h00000000
`define SETPOINT_RESET 16'h0000
`define PGAIN_RESET 16'h0064
`define IPERIOD_RESET 16'h0258
`define IPERIOD_OFF 16'h176f
`define MANUAL_RESET 16'h0000
`define SCALE_GAIN_RESET 16'h0064
`define SCALE_OFFSET_RESET 16'h0000
`define PV_MIN_RESET 16'hd8f0
`define PV_MAX_RESET 16'h4e20
`define OUT_MIN 32'sh00000000
`define OUT_MAX 32'sh000003e8
`define SAMPLE_MS 500
`define CLK_MHZ 100
`define SAMPLE_CYCLES (`SAMPLE_MS * 1000 * `CLK_MHZ)
`endif

//--- logic/pi_process_controller.v
// pi process controller with avalon-mm register slave
// assumes pins from outside, sampled through three flops; one 100 MHz clock
// Overview of operation
// R1: auto_manual_select 1 auto, 0 manual
// R2: reset input forces output zero, mode ignored
// R3: output held within 0 to 1000
// R4: setpoint accepted from -10000 to 20000
// R5: gain 0..99.99; zero gain drops p term
// R6: period 1..5999 s; maximum drops integral term
// R7: manual mode outputs manual value 0..1000
// R8: entering auto seeds integral with manual value
// R9: scaled value is raw times gain plus offset
// R10: scaled value clamped to min/max limits
// R11: limits accepted from -10000 to 20000
// R12: scaled equal setpoint leaves output unchanged
// R13: positive sense: above lowers, below raises
// R14: negative sense: above raises, below lowers
// R15: sense not changed while running
// R16: decimals setting affects display only
// R17: setpoint/manual value may come from another block
// R18: control law evaluated every 500 ms
// R19: output and integral saturate, no windup
// R20: output is gain times error plus integral
`include "pi_ctrl_regs.vh"
module pi_process_controller #(
   parameter SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] address_i,
   input wire read_i,
   input wire write_i,
   input wire [31:0] writedata_i,
   input wire [3:0] byteenable_i,
   output reg [31:0] readdata_o,
   output reg waitrequest_o,
   input wire auto_manual_select_i,
   input wire reset_input_i,
   input wire signed [15:0] process_value_i,
   input wire signed [15:0] ext_setpoint_i,
   input wire signed [15:0] ext_manual_i,
   output reg [9:0] analog_output_o
);
   // ****************************************
   // input synchronisers
   // ****************************************
   reg [2:0] am_sync_reg;
   reg [2:0] rs_sync_reg;
   reg auto_reg;
   reg rin_reg;
   always @(posedge clk_i) begin
      if (rst_i) begin
         am_sync_reg <= 3'h0;
         rs_sync_reg <= 3'h0;
         auto_reg <= 1'b0;
         rin_reg <= 1'b0;
      end else begin
         am_sync_reg <= {am_sync_reg[1:0], auto_manual_select_i};
         rs_sync_reg <= {rs_sync_reg[1:0], reset_input_i};
         if (am_sync_reg[1] == am_sync_reg[2])
            auto_reg <= am_sync_reg[2];
         if (rs_sync_reg[1] == rs_sync_reg[2])
            rin_reg <= rs_sync_reg[2];
      end
   end
   // ****************************************
   // analog word synchronisers
   // ****************************************
   // each word passes three stages; it is taken only when stages two and
   // three agree, so a word caught mid-change never reaches the arithmetic
   // limitation: a word that never holds still for two cycles keeps its
   // last agreed value for as long as it keeps changing, so the lag has no bound
   wire [47:0] word_pins = {ext_manual_i, ext_setpoint_i, process_value_i};
   wire [47:0] word_q;
   genvar w;
   generate
      for (w = 0; w < 3; w = w + 1) begin : word_sync
         reg [15:0] s1_reg;
         reg [15:0] s2_reg;
         reg [15:0] s3_reg;
         reg [15:0] held_reg;
         always @(posedge clk_i) begin
            if (rst_i) begin
               s1_reg <= 16'h0000;
               s2_reg <= 16'h0000;
               s3_reg <= 16'h0000;
               held_reg <= 16'h0000;
            end else begin
               s1_reg <= word_pins[w*16 +: 16];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg)
                  held_reg <= s3_reg;
            end
         end
         assign word_q[w*16 +: 16] = held_reg;
      end
   endgenerate
   // raw process value from the sensor side
   wire signed [15:0] pv_word = word_q[15:0];
   // setpoint offered by another block
   wire signed [15:0] sp_word = word_q[31:16];
   // manual value offered by another block
   wire signed [15:0] mq_word = word_q[47:32];
   // ****************************************
   // register file
   // ****************************************
   reg [31:0] ctrl_reg;
   reg signed [15:0] sp_reg;
   reg [15:0] pgain_reg;
   reg [15:0] iper_reg;
   reg [15:0] man_reg;
   reg signed [15:0] sgain_reg;
   reg signed [15:0] soff_reg;
   reg signed [15:0] pvmin_reg;
   reg signed [15:0] pvmax_reg;
   reg signed [15:0] pvs_reg;
   reg [9:0] out_reg;
   reg run_reg;
   reg [31:0] rd_next;
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] be;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1)
            if (be[k])
               merge[k*8 +: 8] = nw[k*8 +: 8];
      end
   endfunction
   function signed [15:0] clip;
      input signed [15:0] v;
      input signed [15:0] lo;
      input signed [15:0] hi;
      begin
         clip = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction
   function [15:0] cap;
      input [15:0] v;
      input [15:0] hi;
      begin
         cap = (v > hi) ? hi : v;
      end
   endfunction
   function signed [31:0] sat_out;
      input signed [31:0] v;
      begin
         sat_out = (v > `OUT_MAX) ? `OUT_MAX : ((v < `OUT_MIN) ? `OUT_MIN : v);
      end
   endfunction
   // ****************************************
   // bus handshake and register writes
   // ****************************************
   wire [31:0] wm = merge(32'h00000000, writedata_i, byteenable_i);
   // a write lands on the edge that sees waitrequest low, when the master
   // also completes, so a write is never applied twice or too early
   wire wr_hit = write_i && !waitrequest_o;
   // sense bit kept while running, so direction cannot flip mid-control
   wire [31:0] ctrl_merged = merge(ctrl_reg, writedata_i, byteenable_i);
   wire [31:0] ctrl_locked = {ctrl_merged[31:2], ctrl_reg[`CTRL_SENSE_BIT], ctrl_merged[0]};
   // one wait cycle per access: waitrequest drops on the second cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= `CTRL_RESET;
         sp_reg <= `SETPOINT_RESET;
         pgain_reg <= `PGAIN_RESET;
         iper_reg <= `IPERIOD_RESET;
         man_reg <= `MANUAL_RESET;
         sgain_reg <= `SCALE_GAIN_RESET;
         soff_reg <= `SCALE_OFFSET_RESET;
         pvmin_reg <= `PV_MIN_RESET;
         pvmax_reg <= `PV_MAX_RESET;
         waitrequest_o <= 1'b1;
         readdata_o <= 32'h00000000;
      end else begin
         if ((read_i || write_i) && waitrequest_o)
            waitrequest_o <= 1'b0;
         else
            waitrequest_o <= 1'b1;
         readdata_o <= rd_next;
         if (wr_hit) begin
            case (address_i)
               `OFS_CTRL: ctrl_reg <= run_reg ? ctrl_locked : ctrl_merged; // R15
               `OFS_SETPOINT: sp_reg <= clip(wm[15:0], 16'shd8f0, 16'sh4e20); // R4
               `OFS_PGAIN: pgain_reg <= cap(wm[15:0], 16'd9999); // R5
               `OFS_IPERIOD: iper_reg <= (wm[15:0] == 16'h0000) ? 16'h0001 :
                  ((wm[15:0] > `IPERIOD_OFF) ? `IPERIOD_OFF : wm[15:0]); // R6
               `OFS_MANUAL: man_reg <= cap(wm[15:0], 16'd1000); // R7
               `OFS_SCALE_GAIN: sgain_reg <= clip(wm[15:0], -16'sd1000, 16'sd1000); // R9
               `OFS_SCALE_OFFSET: soff_reg <= clip(wm[15:0], -16'sd10000, 16'sd10000);
               `OFS_PV_MIN: pvmin_reg <= clip(wm[15:0], 16'shd8f0, 16'sh4e20); // R11
               `OFS_PV_MAX: pvmax_reg <= clip(wm[15:0], 16'shd8f0, 16'sh4e20); // R11
               default: ctrl_reg <= ctrl_reg;
            endcase
         end
      end
   end
   always @* begin
      rd_next = 32'h00000000;
      if (read_i && waitrequest_o) begin
         case (address_i)
            `OFS_CTRL: rd_next = ctrl_reg;
            `OFS_SETPOINT: rd_next = {{16{sp_reg[15]}}, sp_reg};
            `OFS_PGAIN: rd_next = {16'h0000, pgain_reg};
            `OFS_IPERIOD: rd_next = {16'h0000, iper_reg};
            `OFS_MANUAL: rd_next = {16'h0000, man_reg};
            `OFS_SCALE_GAIN: rd_next = {{16{sgain_reg[15]}}, sgain_reg};
            `OFS_SCALE_OFFSET: rd_next = {{16{soff_reg[15]}}, soff_reg};
            `OFS_PV_MIN: rd_next = {{16{pvmin_reg[15]}}, pvmin_reg};
            `OFS_PV_MAX: rd_next = {{16{pvmax_reg[15]}}, pvmax_reg};
            `OFS_STATUS: rd_next = {29'h0, rin_reg, run_reg, auto_reg};
            `OFS_PV_SCALED: rd_next = {{16{pvs_reg[15]}}, pvs_reg};
            `OFS_OUTPUT: rd_next = {22'h0, out_reg};
            default: rd_next = 32'h00000000;
         endcase
      end
   end
   // display decimals bits [5:4] are stored and read back only
   // R16
   // ****************************************
   // sample tick
   // ****************************************
   reg [31:0] tick_cnt_reg;
   reg tick_reg;
   always @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt_reg <= 32'h00000000;
         tick_reg <= 1'b0;
      end else if (tick_cnt_reg == SAMPLE_CYCLES - 1) begin
         tick_cnt_reg <= 32'h00000000; // R18
         tick_reg <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
         tick_reg <= 1'b0;
      end
   end
   // ****************************************
   // control arithmetic
   // ****************************************
   // sources selectable: own register or another block's actual value
   wire signed [15:0] sp_src = ctrl_reg[`CTRL_SP_SRC_BIT] ?
      clip(sp_word, 16'shd8f0, 16'sh4e20) : sp_reg; // R17
   wire signed [15:0] mq_raw = ctrl_reg[`CTRL_MQ_SRC_BIT] ?
      clip(mq_word, 16'sh0000, 16'sh03e8) : $signed(man_reg); // R17
   // gain is hundredths; 32-bit keeps the product exact
   wire signed [31:0] pv_prod = pv_word * sgain_reg;
   wire signed [31:0] pv_lin = pv_prod / 32'sd100 + soff_reg; // R9
   wire signed [31:0] pv_clamp = (pv_lin > pvmax_reg) ? pvmax_reg :
      ((pv_lin < pvmin_reg) ? pvmin_reg : pv_lin); // R10
   wire signed [31:0] diff = sp_src - pv_clamp;
   wire signed [31:0] err = ctrl_reg[`CTRL_SENSE_BIT] ? -diff : diff; // R13 R14
   wire signed [31:0] p_term = (pgain_reg == 16'h0000) ? 32'sh0 :
      (err * $signed({16'h0000, pgain_reg})) / 32'sd100; // R5
   // integral period in seconds; two samples per second
   wire signed [31:0] i_step = (iper_reg == `IPERIOD_OFF) ? 32'sh0 :
      err / $signed({15'h0000, iper_reg, 1'b0}); // R6
   reg signed [31:0] integ_reg;
   wire signed [31:0] integ_sum = integ_reg + i_step;
   // clamping the accumulator too keeps it from winding up at a limit
   wire signed [31:0] integ_sat = sat_out(integ_sum); // R19
   wire signed [31:0] u_raw = integ_sat + p_term; // R20
   wire signed [31:0] u_sat = sat_out(u_raw); // R3 R19
   // ****************************************
   // mode selection and output stage
   // ****************************************
   always @(posedge clk_i) begin
      if (rst_i) begin
         integ_reg <= 32'sh0;
         run_reg <= 1'b0;
         out_reg <= 10'h000;
         pvs_reg <= 16'h0000;
         analog_output_o <= 10'h000;
      end else begin
         if (tick_reg)
            pvs_reg <= pv_clamp[15:0];
         if (rin_reg) begin
            out_reg <= 10'h000; // R2
            run_reg <= 1'b0;
         end else if (!auto_reg) begin
            out_reg <= mq_raw[9:0]; // R7 R1
            run_reg <= 1'b0;
         end else if (!run_reg) begin
            integ_reg <= {{16{mq_raw[15]}}, mq_raw}; // R8
            out_reg <= mq_raw[9:0];
            run_reg <= 1'b1;
         end else if (tick_reg && diff != 32'sh0) begin
            integ_reg <= integ_sat; // R12
            out_reg <= u_sat[9:0];
         end
         analog_output_o <= rin_reg ? 10'h000 : out_reg; // R2
      end
   end
endmodule

//--- testbench/pi_ctrl_sva.sv
// checker: bus handshake, output range, reset-input relations
// assumes bind from the bench top; one clock, sync reset rst_i
module pi_ctrl_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] readdata_o,
   input wire logic waitrequest_o,
   input wire logic reset_input_i,
   input wire logic [9:0] analog_output_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_OUT_RANGE: assert property (analog_output_o <= 10'h3e8)
      else $error("output over 1000");
   // eight cycles covers the three-flop pin filter
   AST_RIN_ZERO: assert property (reset_input_i [*8] |-> analog_output_o == 10'h0)
      else $error("reset input left output set");
   AST_RIN_HOLD: assert property (reset_input_i [*8] |=> $stable(analog_output_o))
      else $error("output moved under reset input");
   AST_RST_REL: assert property ($fell(rst_i) |-> analog_output_o == 10'h0 && waitrequest_o)
      else $error("bad state after reset");
   AST_ACCEPT: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("request not answered");
   AST_ONE_WAIT: assert property (!waitrequest_o |=> waitrequest_o)
      else $error("answer held too long");
   AST_WAIT_CAUSE: assert property ($fell(waitrequest_o) |-> $past(read_i) || $past(write_i))
      else $error("answer without request");
   AST_UNMAPPED: assert property (read_i && waitrequest_o && address_i > 8'h2c
      |=> readdata_o == 32'h0)
      else $error("unmapped read not zero");
   COV_WRITE: cover property (write_i && !waitrequest_o);
   COV_READ: cover property (read_i && !waitrequest_o);
   COV_RIN: cover property (reset_input_i [*8]);
endmodule

//--- testbench/pv_sensor_model.sv
// sensor model: hands the bench's process level to the block
// assumes one clock; registered once, like a sampled transducer
module pv_sensor_model (
   input wire logic clk_i,
   input wire logic signed [15:0] level_i,
   output logic signed [15:0] process_value_o
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge clk_i) process_value_o <= level_i;
endmodule

//--- testbench/pi_process_controller_tb.sv
// bench: bus tasks, scenarios and verdict for the pi controller
// assumes hand-over bus timing; sample interval cut to 20 cycles
`include "pi_ctrl_regs.vh"
module pi_process_controller_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, read_i = 0, write_i = 0, auto_i = 0, rin_i = 0, waitrequest_o;
   logic [7:0] address_i = 8'h0;
   logic [31:0] writedata_i = 32'h0, readdata_o, rd;
   logic [9:0] out, last;
   logic signed [15:0] level = 16'sh1f4, pv;
   logic signed [15:0] ext_sp = 16'sh0, ext_mq = 16'sh0;
   int fails = 0, check_count = 0;
   always #5 clk_i = ~clk_i;
   pv_sensor_model pv_sensor_model_inst (.clk_i(clk_i), .level_i(level), .process_value_o(pv));
   pi_process_controller #(.SAMPLE_CYCLES(20)) pi_process_controller_inst (
      .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hf),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
      .auto_manual_select_i(auto_i), .reset_input_i(rin_i), .process_value_i(pv),
      .ext_setpoint_i(ext_sp), .ext_manual_i(ext_mq), .analog_output_o(out));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // waits unbounded; only the watchdog cuts a hung handshake
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      address_i <= a;
      writedata_i <= d;
      write_i <= wr;
      read_i <= !wr;
      @(posedge clk_i);
      while (waitrequest_o !== 1'b0) @(posedge clk_i);
      rd = readdata_o;
      write_i <= 1'b0;
      read_i <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic s_regs;
      rchk(`OFS_PGAIN, 32'h64);
      rchk(`OFS_IPERIOD, 32'h258);
      rchk(`OFS_PV_MIN, 32'hffffd8f0);
      bus(1'b1, 8'h30, 32'h1234);
      rchk(8'h30, 32'h0);
      bus(1'b1, `OFS_SETPOINT, 32'h61a8);
      rchk(`OFS_SETPOINT, 32'h4e20);
      bus(1'b1, `OFS_SETPOINT, 32'h1f4);
   endtask
   task automatic s_manual;
      bus(1'b1, `OFS_MANUAL, 32'h2bc);
      cyc(10);
      chk(out, 32'h2bc);
      bus(1'b1, `OFS_MANUAL, 32'h5dc);
      cyc(10);
      chk(out, 32'h3e8);
      rin_i <= 1'b1;
      auto_i <= 1'b1;
      cyc(10);
      chk(out, 32'h0);
      rin_i <= 1'b0;
      auto_i <= 1'b0;
      cyc(10);
      chk(out, 32'h3e8);
   endtask
   task automatic s_auto;
      bus(1'b1, `OFS_MANUAL, 32'h190);
      cyc(10);
      auto_i <= 1'b1;
      cyc(100);
      chk(out, 32'h190);
      rchk(`OFS_PV_SCALED, 32'h1f4);
      level <= 16'sh12c;
      cyc(100);
      chk(out > 10'h190, 32'h1);
      last = out;
      level <= 16'sh2bc;
      cyc(100);
      chk(out < last, 32'h1);
      bus(1'b1, `OFS_SCALE_GAIN, 32'hc8);
      bus(1'b1, `OFS_SCALE_OFFSET, 32'ha);
      level <= 16'sh64;
      cyc(60);
      rchk(`OFS_PV_SCALED, 32'hd2);
      level <= 16'shdcd8;
      cyc(60);
      rchk(`OFS_PV_SCALED, 32'hffffd8f0);
      bus(1'b1, `OFS_PGAIN, 32'h0);
      bus(1'b1, `OFS_IPERIOD, 32'h176f);
      cyc(60);
      last = out;
      cyc(100);
      chk(out, last);
   endtask
   task automatic s_neg;
      auto_i <= 1'b0;
      cyc(10);
      // direction only changed while stopped
      bus(1'b1, `OFS_CTRL, 32'h32);
      bus(1'b1, `OFS_PGAIN, 32'h64);
      bus(1'b1, `OFS_SCALE_GAIN, 32'h64);
      bus(1'b1, `OFS_SCALE_OFFSET, 32'h0);
      level <= 16'sh2bc;
      cyc(10);
      auto_i <= 1'b1;
      cyc(100);
      chk(out > 10'h190, 32'h1);
   endtask
   task automatic s_ext;
      auto_i <= 1'b0;
      ext_mq <= 16'sh0fa;
      cyc(10);
      bus(1'b1, `OFS_CTRL, 32'h8);
      cyc(10);
      chk(out, 32'hfa);
      ext_mq <= 16'sh7d0;
      cyc(10);
      chk(out, 32'h3e8);
      ext_mq <= 16'sh12c;
      ext_sp <= 16'sh2bc;
      bus(1'b1, `OFS_CTRL, 32'hc);
      cyc(10);
      auto_i <= 1'b1;
      cyc(100);
      chk(out, 32'h12c);
   endtask
   task automatic close_out;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      cyc(8);
      rst_i <= 1'b0;
      cyc(2);
      s_regs;
      s_manual;
      s_auto;
      s_neg;
      s_ext;
      close_out;
   end
   initial begin
      #100us;
      fails++;
      close_out;
   end
endmodule
bind pi_process_controller pi_ctrl_sva pi_ctrl_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
   .address_i(address_i), .read_i(read_i), .write_i(write_i), .readdata_o(readdata_o),
   .waitrequest_o(waitrequest_o), .reset_input_i(reset_input_i),
   .analog_output_o(analog_output_o));
